// ===== dv/i2c_bus_model.sv
// far side of the two buses: makes start and stop conditions on the pins
// assumes pclk from the bench; pins idle high through pull-ups
`timescale 1ns/1ps
`default_nettype none

module i2c_bus_model
  import i2c_fifo_pkg::*;
(
  input wire logic                  pclk,
  output line_pins_s [INSTANCES-1:0] pins
);
  // ==========================================================================
  // conditions
  initial pins = '1;
  // levels held six cycles so the two-stage synchroniser sees each one
  task automatic start(input int k);
    @(posedge pclk);
    pins[k] <= '{scl: 1'b1, sda: 1'b1};
    repeat (6) @(posedge pclk);
    pins[k].sda <= 1'b0;
    repeat (6) @(posedge pclk);
    pins[k].scl <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : start
  task automatic stop(input int k);
    @(posedge pclk);
    pins[k] <= '{scl: 1'b0, sda: 1'b0};
    repeat (6) @(posedge pclk);
    pins[k].scl <= 1'b1;
    repeat (6) @(posedge pclk);
    pins[k].sda <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : stop
endmodule : i2c_bus_model

`default_nettype wire

// ===== dv/i2c_fifo_status_and_flush_monitor.sv
// concurrent checks on the fill status / shared reset block ports
// assumes binding to the top module, one pclk domain
`timescale 1ns/1ps
`default_nettype none

module i2c_fifo_status_and_flush_monitor
  import i2c_fifo_pkg::*;
(
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [APB_ADDR_W-1:0]        paddr,
  input wire logic [APB_DATA_W-1:0]        pwdata,
  input wire logic [APB_STRB_W-1:0]        pstrb,
  input wire logic [APB_DATA_W-1:0]        prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire fifo_req_s [FIFO_COUNT-1:0]   fifo_req,
  input wire fifo_state_s [FIFO_COUNT-1:0] fifo_state,
  input wire line_pins_s [INSTANCES-1:0]   line_pins,
  input wire line_events_s [INSTANCES-1:0] line_events
);
  // ==========================================================================
  // helpers
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       mapped = paddr == FILL_STATUS_ADDR[0] ||
      paddr == FILL_STATUS_ADDR[1] || paddr == SHARED_RESET_ADDR[0] ||
      paddr == SHARED_RESET_ADDR[1];
  wire [7:0] cnt0   = {fifo_state[3].count, fifo_state[2].count,
      fifo_state[1].count, fifo_state[0].count};
  logic      over;
  always_comb begin
    over = 1'b0;
    for (int i = 0; i < FIFO_COUNT; i++) begin
      if (fifo_state[i].count > 2'h2) over = 1'b1;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_done;
    psel && penable && pready && pwrite;
  endsequence

  // ==========================================================================
  // assertions
  a_one_wait: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_fill_read: assert property (s_setup ##0 (!pwrite &&
      paddr == FILL_STATUS_ADDR[0]) |=> prdata == {24'h0, $past(cnt0)})
    else $error("fill status read wrong");
  a_depth_max: assert property (!over)
    else $error("fifo count above two");
  a_mpurge_empty: assert property (s_wr_done ##0 (pwdata[9] &&
      pstrb[1] && paddr == FILL_STATUS_ADDR[0]) |-> ##2
      fifo_state[2].count == 2'h0)
    else $error("master purge left bytes");
  a_spurge_second: assert property (s_wr_done ##0 (pwdata[8] &&
      pstrb[1] && paddr == FILL_STATUS_ADDR[1]) |-> ##2
      fifo_state[4].count == 2'h0)
    else $error("slave purge left bytes");
  a_unmapped_err: assert property (s_setup ##0 !mapped |=>
      pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_shared_zero: assert property (s_setup ##0 (!pwrite &&
      paddr == SHARED_RESET_ADDR[0]) |=> !pslverr && prdata == 32'h0)
    else $error("shared register read not zero");
  a_detect_clear: assert property (s_wr_done ##0 (pwdata[0] &&
      pstrb[0] && paddr == SHARED_RESET_ADDR[0]) |-> ##2
      (!line_events[0].busy || line_events[0].start))
    else $error("busy not cleared by detect reset");
  a_start_pulse: assert property (line_events[0].start |=>
      !line_events[0].start)
    else $error("start event longer than one cycle");
  a_stop_ends: assert property (line_events[0].stop |->
      !line_events[0].busy)
    else $error("busy still set at stop event");
endmodule : i2c_fifo_status_and_flush_monitor

`default_nettype wire

// ===== dv/i2c_fifo_status_and_flush_test.sv
// self-checking bench: apb register accesses, fifo traffic, bus conditions
// assumes the monitor and the bus model are compiled first
`timescale 1ns/1ps
`default_nettype none

module i2c_fifo_status_and_flush_test
  import i2c_fifo_pkg::*;
;
  logic                         pclk, presetn, psel, penable, pwrite;
  logic [31:0]                  paddr, pwdata, prdata, rd;
  logic [3:0]                   pstrb;
  logic                         pready, pslverr, err;
  fifo_req_s [FIFO_COUNT-1:0]   fifo_req;
  fifo_state_s [FIFO_COUNT-1:0] fifo_state;
  line_pins_s [INSTANCES-1:0]   line_pins;
  line_events_s [INSTANCES-1:0] line_events;
  int                           n_fail, cmp_count;

  i2c_fifo_status_and_flush dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifo_req(fifo_req), .fifo_state(fifo_state),
    .line_pins(line_pins), .line_events(line_events));
  i2c_bus_model bus (.pclk(pclk), .pins(line_pins));

  // ==========================================================================
  // tasks
  task automatic print_verdict;
    $display("mismatches %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic [31:0] a, input logic [31:0] wd,
                     input logic wr);
    int t;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic fifo_cycle(input logic [7:0] pu, input logic [7:0] po,
                            input logic [7:0] d);
    @(posedge pclk);
    for (int i = 0; i < FIFO_COUNT; i++) begin
      fifo_req[i] <= '{push: pu[i], push_data: d, pop: po[i]};
    end
  endtask : fifo_cycle

  // ==========================================================================
  // clock, watchdog, tests
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #(25 * 8000);
    n_fail++;
    print_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    fifo_req = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      apb(FILL_STATUS_ADDR[k], 32'h0, 1'b0);
      chk(rd, 32'h0);
    end
    // three pushes into every fifo: the third finds it full
    for (int c = 0; c < 3; c++) fifo_cycle(8'hFF, 8'h00, 8'(8'h10 + c));
    fifo_cycle(8'h00, 8'h0A, 8'h00);
    fifo_cycle(8'h00, 8'h08, 8'h00);
    fifo_cycle(8'h00, 8'h00, 8'h00);
    @(posedge pclk);
    chk({24'h0, fifo_state[1].head}, 32'h11);
    apb(FILL_STATUS_ADDR[0], 32'h0, 1'b0);
    chk(rd, 32'h26);
    apb(FILL_STATUS_ADDR[1], 32'h0, 1'b0);
    chk(rd, 32'hAA);
    apb(FILL_STATUS_ADDR[0], 32'h0, 1'b1);
    apb(FILL_STATUS_ADDR[0], 32'h0, 1'b0);
    chk(rd, 32'h26);
    apb(FILL_STATUS_ADDR[0], 32'h200, 1'b1);
    apb(FILL_STATUS_ADDR[0], 32'h0, 1'b0);
    chk(rd, 32'h06);
    apb(FILL_STATUS_ADDR[1], 32'h100, 1'b1);
    apb(FILL_STATUS_ADDR[1], 32'h0, 1'b0);
    chk(rd, 32'hA8);
    apb(32'h4000_3054, 32'h0, 1'b0);
    chk({rd[30:0], err}, 32'h1);
    apb(SHARED_RESET_ADDR[0], 32'h0, 1'b0);
    chk({rd[30:0], err}, 32'h0);
    for (int k = 0; k < 2; k++) begin
      bus.start(k);
      #1;
      chk({31'h0, line_events[k].busy}, 32'h1);
      apb(SHARED_RESET_ADDR[k], 32'h1, 1'b1);
      repeat (2) @(posedge pclk);
      #1;
      chk({31'h0, line_events[k].busy}, 32'h0);
      bus.start(k);
      #1;
      chk({31'h0, line_events[k].busy}, 32'h1);
      bus.stop(k);
      #1;
      chk({31'h0, line_events[k].busy}, 32'h0);
    end
    print_verdict;
  end
endmodule : i2c_fifo_status_and_flush_test

bind i2c_fifo_status_and_flush i2c_fifo_status_and_flush_monitor mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fifo_req(fifo_req), .fifo_state(fifo_state), .line_pins(line_pins),
  .line_events(line_events));

`default_nettype wire

// ===== inc/i2c_fifo_pkg.sv
// shared constants and carriers for the fifo fill status / shared control
// block; assumes a 32-bit apb bus and one peripheral clock
package i2c_fifo_pkg;

  // ==========================================================================
  // structure
  localparam int unsigned INSTANCES      = 2;
  localparam int unsigned FIFOS_PER_INST = 4;
  localparam int unsigned FIFO_COUNT     = INSTANCES * FIFOS_PER_INST;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned FIFO_DEPTH     = 2;
  localparam int unsigned COUNT_W        = 2;
  localparam int unsigned REG_W          = 16;
  localparam int unsigned APB_DATA_W     = 32;
  localparam int unsigned APB_ADDR_W     = 32;
  localparam int unsigned APB_STRB_W     = 4;

  // ==========================================================================
  // fifo index within one controller
  localparam int unsigned FIFO_SLAVE_TX  = 0;
  localparam int unsigned FIFO_SLAVE_RX  = 1;
  localparam int unsigned FIFO_MASTER_TX = 2;
  localparam int unsigned FIFO_MASTER_RX = 3;

  // ==========================================================================
  // register byte addresses, element 0 is the first controller
  localparam logic [INSTANCES-1:0][APB_ADDR_W-1:0] FILL_STATUS_ADDR =
    {32'h4000_344C, 32'h4000_304C};
  localparam logic [INSTANCES-1:0][APB_ADDR_W-1:0] SHARED_RESET_ADDR =
    {32'h4000_3450, 32'h4000_3050};

  // ==========================================================================
  // field positions and reset values
  localparam int unsigned MASTER_TX_PURGE_BIT = 9;
  localparam int unsigned SLAVE_TX_PURGE_BIT  = 8;
  localparam int unsigned MASTER_RX_FILL_LSB  = 6;
  localparam int unsigned MASTER_TX_FILL_LSB  = 4;
  localparam int unsigned SLAVE_RX_FILL_LSB   = 2;
  localparam int unsigned SLAVE_TX_FILL_LSB   = 0;
  localparam int unsigned DETECT_RESET_BIT    = 0;
  localparam logic [REG_W-1:0] FILL_STATUS_RESET  = 16'h0000;
  localparam logic [REG_W-1:0] SHARED_RESET_VALUE = 16'h0000;

  // ==========================================================================
  // carriers
  typedef enum logic [0:0] {
    LINE_IDLE = 1'b0,
    LINE_BUSY = 1'b1
  } line_state_e;

  typedef struct packed {
    logic              push;
    logic [BYTE_W-1:0] push_data;
    logic              pop;
  } fifo_req_s;

  typedef struct packed {
    logic [BYTE_W-1:0]  head;
    logic [COUNT_W-1:0] count;
  } fifo_state_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_pins_s;

  typedef struct packed {
    logic busy;
    logic start;
    logic stop;
  } line_events_s;

endpackage : i2c_fifo_pkg

// ===== rtl/i2c_byte_pair_fifo.sv
// small byte fifo used for each transmit and receive queue
// assumes push/pop come from logic on pclk; purge is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none

module i2c_byte_pair_fifo
  import i2c_fifo_pkg::*;
#(
  parameter int unsigned WIDTH = BYTE_W,
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned CNT_W = COUNT_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             purge,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head_data,
  output logic      [CNT_W-1:0] count
);

  // ==========================================================================
  // control
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_pop;
  logic             do_push;
  logic [CNT_W-1:0] wr_idx;

  // a purge swallows any push or pop of the same cycle
  assign do_pop  = pop && (count != '0) && !purge;
  assign do_push = push && !purge &&
                   ((count < CNT_W'(DEPTH)) || do_pop);
  assign wr_idx  = do_pop ? count - CNT_W'(1) : count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (purge) begin
      count <= '0;
    end else begin
      case ({do_push, do_pop})
        2'b10:   count <= count + CNT_W'(1);
        2'b01:   count <= count - CNT_W'(1);
        default: count <= count;
      endcase
    end
  end

  // ==========================================================================
  // storage, head always in entry 0
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem[i] <= '0;
      end else if (do_push && (wr_idx == CNT_W'(i))) begin
        mem[i] <= push_data;
      end else if (do_pop) begin
        if (i < DEPTH - 1) begin
          mem[i] <= mem[(i < DEPTH - 1) ? i + 1 : i];
        end
      end
    end
  end

  assign head_data = mem[0];

endmodule : i2c_byte_pair_fifo

`default_nettype wire

// ===== rtl/i2c_fifo_status_and_flush.sv
// fifo fill status and shared detect reset for two bus controllers
// assumes an apb master on pclk, bus pins asynchronous to pclk, and the
// shifting logic driving fifo push/pop on pclk
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - writing one to master purge bit empties master transmit fifo, zero does nothing
// - writing one to slave purge bit empties slave transmit fifo, zero does nothing
// - bits 7:6 show master receive fifo byte count, 0 to 2
// - bits 5:4 show master transmit fifo byte count, 0 to 2
// - bits 3:2 show slave receive fifo byte count, 0 to 2
// - bits 1:0 show slave transmit fifo byte count, 0 to 2
// - fill status register reads all zeros after reset
// - writing one to shared bit 0 resets start and stop detection
// - the same write clears the bus occupied flag unless a start is seen in the cycle the reset acts
// - second controller has identical registers at its own addresses
module i2c_fifo_status_and_flush
  import i2c_fifo_pkg::*;
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [APB_ADDR_W-1:0]      paddr,
  input  wire logic [APB_DATA_W-1:0]      pwdata,
  input  wire logic [APB_STRB_W-1:0]      pstrb,
  output logic      [APB_DATA_W-1:0]      prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire fifo_req_s [FIFO_COUNT-1:0] fifo_req,
  output fifo_state_s    [FIFO_COUNT-1:0] fifo_state,
  input  wire line_pins_s [INSTANCES-1:0] line_pins,
  output line_events_s    [INSTANCES-1:0] line_events
);

  // ==========================================================================
  // apb decode
  logic [INSTANCES-1:0] fill_hit;
  logic [INSTANCES-1:0] shared_hit;
  logic                 any_hit;
  logic                 setup_phase;
  logic                 wr_access;
  logic [REG_W-1:0]     fill_word [INSTANCES];
  logic [REG_W-1:0]     next_read;

  assign setup_phase = psel && !penable;
  assign wr_access   = psel && penable && pready && pwrite;
  assign any_hit     = |{fill_hit, shared_hit};

  // the second controller decodes its own pair of addresses
  for (genvar i = 0; i < INSTANCES; i++) begin : g_decode
    assign fill_hit[i]   = (paddr == FILL_STATUS_ADDR[i]);
    assign shared_hit[i] = (paddr == SHARED_RESET_ADDR[i]);
  end

  // ==========================================================================
  // read mux
  // purge bits and the whole shared register are write-only and read zero
  always_comb begin
    next_read = '0;
    for (int k = 0; k < INSTANCES; k++) begin
      if (fill_hit[k]) begin
        next_read = fill_word[k];
      end
    end
  end

  // ==========================================================================
  // apb answer: no wait state, pready high in every access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // read data is captured at the setup edge; counts may still move before
  // the access edge, which software sees as an ordinary sampling delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase) begin
      prdata <= (!pwrite) ? APB_DATA_W'(next_read) : '0;
    end
  end

  // unmapped addresses answer with an error and have no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= !any_hit;
    end
  end

  // ==========================================================================
  // per controller: command pulses, fifos, line watch
  for (genvar i = 0; i < INSTANCES; i++) begin : g_ctrl

    localparam int unsigned BASE = i * FIFOS_PER_INST;

    logic master_purge;
    logic slave_purge;
    logic detect_reset;
    logic master_set;
    logic slave_set;
    logic detect_set;

    // byte lane 1 carries the purge bits, lane 0 the detect reset bit
    assign master_set = wr_access && fill_hit[i] && pstrb[1] &&
                        pwdata[MASTER_TX_PURGE_BIT];
    assign slave_set  = wr_access && fill_hit[i] && pstrb[1] &&
                        pwdata[SLAVE_TX_PURGE_BIT];
    assign detect_set = wr_access && shared_hit[i] && pstrb[0] &&
                        pwdata[DETECT_RESET_BIT];

    // each command bit acts in the one cycle after the write, then clears
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        master_purge <= FILL_STATUS_RESET[MASTER_TX_PURGE_BIT];
      end else begin
        master_purge <= master_set;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        slave_purge <= FILL_STATUS_RESET[SLAVE_TX_PURGE_BIT];
      end else begin
        slave_purge <= slave_set;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        detect_reset <= SHARED_RESET_VALUE[DETECT_RESET_BIT];
      end else begin
        detect_reset <= detect_set;
      end
    end

    // ------------------------------------------------------------------------
    // four queues; only the two transmit queues can be purged by software,
    // software is expected to purge master tx on a lost bus or a nack
    for (genvar f = 0; f < FIFOS_PER_INST; f++) begin : g_fifo
      logic purge_this;

      if (f == FIFO_MASTER_TX) begin : g_mp
        assign purge_this = master_purge;
      end else if (f == FIFO_SLAVE_TX) begin : g_sp
        assign purge_this = slave_purge;
      end else begin : g_np
        assign purge_this = 1'b0;
      end

      i2c_byte_pair_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH),
        .CNT_W (COUNT_W)
      ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .purge     (purge_this),
        .push      (fifo_req[BASE+f].push),
        .push_data (fifo_req[BASE+f].push_data),
        .pop       (fifo_req[BASE+f].pop),
        .head_data (fifo_state[BASE+f].head),
        .count     (fifo_state[BASE+f].count)
      );
    end

    // ------------------------------------------------------------------------
    // fill status word; codes never exceed two since depth is two
    always_comb begin
      fill_word[i] = FILL_STATUS_RESET;
      fill_word[i][MASTER_RX_FILL_LSB +: COUNT_W] =
        fifo_state[BASE+FIFO_MASTER_RX].count;
      fill_word[i][MASTER_TX_FILL_LSB +: COUNT_W] =
        fifo_state[BASE+FIFO_MASTER_TX].count;
      fill_word[i][SLAVE_RX_FILL_LSB +: COUNT_W] =
        fifo_state[BASE+FIFO_SLAVE_RX].count;
      fill_word[i][SLAVE_TX_FILL_LSB +: COUNT_W] =
        fifo_state[BASE+FIFO_SLAVE_TX].count;
    end

    // ------------------------------------------------------------------------
    // pin synchronisers; the first stage feeds only the second
    logic scl_meta;
    logic sda_meta;
    logic scl_sync;
    logic sda_sync;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        scl_meta <= 1'b1;
        sda_meta <= 1'b1;
        scl_sync <= 1'b1;
        sda_sync <= 1'b1;
      end else begin
        scl_meta <= line_pins[i].scl;
        sda_meta <= line_pins[i].sda;
        scl_sync <= scl_meta;
        sda_sync <= sda_meta;
      end
    end

    // ------------------------------------------------------------------------
    // start / stop detection
    logic        scl_prev;
    logic        sda_prev;
    logic        armed;
    logic        start_seen;
    logic        stop_seen;
    line_state_e line_state;
    line_state_e next_line_state;

    // after a detect reset the history is discarded and one cycle passes
    // before edges count, so a stale sample cannot fake a condition
    assign start_seen = armed && scl_prev && scl_sync &&
                        sda_prev && !sda_sync;
    assign stop_seen  = armed && scl_prev && scl_sync &&
                        !sda_prev && sda_sync;

    always_comb begin
      next_line_state = line_state;
      case (line_state)
        LINE_IDLE: begin
          if (start_seen) begin
            next_line_state = LINE_BUSY;
          end
        end
        LINE_BUSY: begin
          if (stop_seen) begin
            next_line_state = LINE_IDLE;
          end
        end
        default: next_line_state = LINE_IDLE;
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        scl_prev <= 1'b1;
        sda_prev <= 1'b1;
        armed    <= 1'b0;
      end else if (detect_reset) begin
        scl_prev <= 1'b1;
        sda_prev <= 1'b1;
        armed    <= 1'b0;
      end else begin
        scl_prev <= scl_sync;
        sda_prev <= sda_sync;
        armed    <= 1'b1;
      end
    end

    // a start seen in the same cycle as a detect reset still sets busy,
    // so a condition that coincides with the command is not lost
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        line_state        <= LINE_IDLE;
        line_events[i]    <= '0;
      end else if (detect_reset) begin
        line_state           <= start_seen ? LINE_BUSY : LINE_IDLE;
        line_events[i].busy  <= start_seen;
        line_events[i].start <= start_seen;
        line_events[i].stop  <= stop_seen;
      end else begin
        line_state           <= next_line_state;
        line_events[i].busy  <= (next_line_state == LINE_BUSY);
        line_events[i].start <= start_seen;
        line_events[i].stop  <= stop_seen;
      end
    end
  end

endmodule : i2c_fifo_status_and_flush

`default_nettype wire
